// File: rtl/brc_ctrl.sv
// Buck ramp control and linear regulator one level register bank
//
// Notes on behaviour
// - Launch bit one starts ramp to setpoints
// - Launch bit self-clears when ramp completes
// - Bypass starts ramp on every setpoint write
// - Bypass-started ramps still follow rate selector
// - One rate and launch for all bucks
// - Forced-PWM bits 5,4,3 hold converters PWM
// - Forced-PWM zero lets converter choose mode
// - Rates 0-3: 224, 112, 56, 28 us
// - Rates 4-6: 14, 7, 3.5 us
// - Rate seven applies setpoint at once
// - Ramp rate is code step over dwell
// - Ramp register at 0x11, resets to 0x06
// - Writes ignored unless password unlock done
// - Regulator code bits 3-0 pick level
// - Regulator top nibble reads zero, resets 0x09
// - Setpoints hold 6-bit code plus external bit
module brc_ctrl import brc_pkg::*; #(
   parameter int DWELL0_CYC = BRC_DWELL0_CYC,
   parameter int DWELL1_CYC = BRC_DWELL1_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire brc_reg_req_t reg_req,
   input wire logic unlocked,
   output logic [7:0] rdata,
   output brc_buck_out_t [BRC_NUM_BUCKS-1:0] buck_out,
   output logic [BRC_LINREG_W-1:0] linreg1_code,
   output logic ramp_busy
);

   typedef struct packed {
      logic launch;
      logic bypass;
      logic [BRC_NUM_BUCKS-1:0] fpwm;
      logic [BRC_RATE_W-1:0] rate;
      logic [BRC_NUM_BUCKS-1:0][7:0] setp;
      logic [BRC_NUM_BUCKS-1:0][BRC_CODE_W-1:0] target;
      logic [BRC_LINREG_W-1:0] linreg;
      logic [7:0] rdata;
      logic [BRC_DWELL_W-1:0] dwell;
      brc_ramp_st_t st;
      logic busy;
   } brc_state_t;

   brc_state_t s_reg;
   brc_state_t s_next;
   logic [BRC_NUM_BUCKS-1:0][BRC_CODE_W-1:0] applied;
   logic [BRC_NUM_BUCKS-1:0] done;
   logic all_done;
   logic tick;
   logic immediate;

   // Dwell reload; counts down to zero inclusive, hence the minus one
   function automatic logic [BRC_DWELL_W-1:0] dwell_load(
      input logic [BRC_RATE_W-1:0] rate
   );
      case (rate)
         3'h0: dwell_load = BRC_DWELL_W'(DWELL0_CYC - 1);
         3'h1: dwell_load = BRC_DWELL_W'(DWELL1_CYC - 1);
         3'h2: dwell_load = BRC_DWELL_W'(BRC_DWELL2_CYC - 1);
         3'h3: dwell_load = BRC_DWELL_W'(BRC_DWELL3_CYC - 1);
         3'h4: dwell_load = BRC_DWELL_W'(BRC_DWELL4_CYC - 1);
         3'h5: dwell_load = BRC_DWELL_W'(BRC_DWELL5_CYC - 1);
         3'h6: dwell_load = BRC_DWELL_W'(BRC_DWELL6_CYC - 1);
         default: dwell_load = '0;
      endcase
   endfunction

   // Index of the setpoint register at an address, or NUM_BUCKS if none
   function automatic int buck_index(input logic [7:0] addr);
      case (addr)
         BRC_ADDR_BUCK1_SET: buck_index = 0;
         BRC_ADDR_BUCK2_SET: buck_index = 1;
         BRC_ADDR_BUCK3_SET: buck_index = 2;
         default: buck_index = BRC_NUM_BUCKS;
      endcase
   endfunction

   // One tick and one rate drive every stepper
   assign tick = (s_reg.st == BRC_RAMP) && (s_reg.dwell == '0);
   assign immediate = (s_reg.rate == BRC_RATE_IMMEDIATE);

   genvar g;
   generate
      for (g = 0; g < BRC_NUM_BUCKS; g = g + 1) begin : g_buck
         brc_stepper #(
            .RESET_CODE(BRC_BUCK_SET_RST[BRC_CODE_W-1:0])
         ) u_step (
            .clk_sys(clk_sys),
            .rst(rst),
            .target(s_reg.target[g]),
            .tick(tick),
            .immediate(immediate),
            .applied(applied[g])
         );
         assign done[g] = (applied[g] == s_reg.target[g]);
         assign buck_out[g].forced_pwm = s_reg.fpwm[g];
         assign buck_out[g].ext_adjust = s_reg.setp[g][BRC_XADJ_BIT];
         assign buck_out[g].code = applied[g];
      end
   endgenerate

   assign all_done = &done;

   always_comb begin
      logic wr_ok;
      int bi;
      wr_ok = reg_req.wr && unlocked;
      bi = buck_index(reg_req.addr);
      s_next = s_reg;

      // Launch clears when finished; a new launch write wins
      if (s_reg.launch && all_done) begin
         s_next.launch = 1'b0;
      end

      if (wr_ok && reg_req.addr == BRC_ADDR_RAMP) begin
         s_next.bypass = reg_req.wdata[BRC_BYPASS_BIT];
         s_next.fpwm[0] = reg_req.wdata[BRC_PWM1_BIT];
         s_next.fpwm[1] = reg_req.wdata[BRC_PWM2_BIT];
         s_next.fpwm[2] = reg_req.wdata[BRC_PWM3_BIT];
         s_next.rate = reg_req.wdata[BRC_RATE_LSB +: BRC_RATE_W];
         if (reg_req.wdata[BRC_LAUNCH_BIT]) begin
            s_next.launch = 1'b1;
            for (int i = 0; i < BRC_NUM_BUCKS; i++) begin
               s_next.target[i] = s_reg.setp[i][BRC_CODE_W-1:0];
            end
         end
      end

      if (wr_ok && bi < BRC_NUM_BUCKS) begin
         s_next.setp[bi] = {reg_req.wdata[BRC_XADJ_BIT], 1'b0,
                            reg_req.wdata[BRC_CODE_W-1:0]};
         // Without bypass the target stays put until launch
         if (s_reg.bypass) begin
            s_next.target[bi] = reg_req.wdata[BRC_CODE_W-1:0];
         end
      end

      if (wr_ok && reg_req.addr == BRC_ADDR_LINREG1) begin
         s_next.linreg = reg_req.wdata[BRC_LINREG_W-1:0];
      end

      // Reads need no unlock; unmapped addresses read zero
      if (reg_req.rd) begin
         s_next.rdata = 8'h00;
         if (reg_req.addr == BRC_ADDR_RAMP) begin
            s_next.rdata[BRC_LAUNCH_BIT] = s_reg.launch;
            s_next.rdata[BRC_BYPASS_BIT] = s_reg.bypass;
            s_next.rdata[BRC_PWM1_BIT] = s_reg.fpwm[0];
            s_next.rdata[BRC_PWM2_BIT] = s_reg.fpwm[1];
            s_next.rdata[BRC_PWM3_BIT] = s_reg.fpwm[2];
            s_next.rdata[BRC_RATE_LSB +: BRC_RATE_W] = s_reg.rate;
         end else if (reg_req.addr == BRC_ADDR_LINREG1) begin
            s_next.rdata = {4'h0, s_reg.linreg};
         end else if (bi < BRC_NUM_BUCKS) begin
            s_next.rdata = s_reg.setp[bi];
         end
      end

      // Dwell sequencer; first step lands one full dwell after start
      case (s_reg.st)
         BRC_IDLE: begin
            if (!all_done) begin
               s_next.st = BRC_RAMP;
               s_next.dwell = dwell_load(s_reg.rate);
            end
         end
         BRC_RAMP: begin
            if (all_done) begin
               s_next.st = BRC_IDLE;
            end else if (s_reg.dwell == '0) begin
               s_next.dwell = dwell_load(s_reg.rate);
            end else begin
               s_next.dwell = s_reg.dwell - 14'h0001;
            end
         end
         default: begin
            s_next.st = BRC_IDLE;
         end
      endcase
      s_next.busy = (s_next.st == BRC_RAMP);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg.launch <= BRC_RAMP_RST[BRC_LAUNCH_BIT];
         s_reg.bypass <= BRC_RAMP_RST[BRC_BYPASS_BIT];
         s_reg.fpwm <= 3'h0;
         s_reg.rate <= BRC_RAMP_RST[BRC_RATE_LSB +: BRC_RATE_W];
         s_reg.setp <= {BRC_NUM_BUCKS{BRC_BUCK_SET_RST}};
         s_reg.target <= {BRC_NUM_BUCKS{BRC_BUCK_SET_RST[BRC_CODE_W-1:0]}};
         s_reg.linreg <= BRC_LINREG1_RST[BRC_LINREG_W-1:0];
         s_reg.rdata <= 8'h00;
         s_reg.dwell <= '0;
         s_reg.st <= BRC_IDLE;
         s_reg.busy <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata = s_reg.rdata;
   assign linreg1_code = s_reg.linreg;
   assign ramp_busy = s_reg.busy;

endmodule // brc_ctrl

// File: rtl/brc_pkg.sv
// Shared constants and types for the buck ramp and linear regulator control
package brc_pkg;

   // Register addresses; buck one and two setpoint placement chosen locally
   localparam logic [7:0] BRC_ADDR_BUCK1_SET = 8'h0e;
   localparam logic [7:0] BRC_ADDR_BUCK2_SET = 8'h0f;
   localparam logic [7:0] BRC_ADDR_BUCK3_SET = 8'h10;
   localparam logic [7:0] BRC_ADDR_RAMP = 8'h11;
   localparam logic [7:0] BRC_ADDR_LINREG1 = 8'h12;

   // Reset values
   localparam logic [7:0] BRC_RAMP_RST = 8'h06;
   localparam logic [7:0] BRC_LINREG1_RST = 8'h09;
   localparam logic [7:0] BRC_BUCK_SET_RST = 8'h08;

   // Ramp control field positions
   localparam int BRC_LAUNCH_BIT = 7;
   localparam int BRC_BYPASS_BIT = 6;
   localparam int BRC_PWM1_BIT = 5;
   localparam int BRC_PWM2_BIT = 4;
   localparam int BRC_PWM3_BIT = 3;
   localparam int BRC_RATE_LSB = 0;
   localparam int BRC_RATE_W = 3;
   localparam logic [2:0] BRC_RATE_IMMEDIATE = 3'h7;

   // Setpoint register fields
   localparam int BRC_XADJ_BIT = 7;
   localparam int BRC_CODE_W = 6;
   localparam int BRC_LINREG_W = 4;
   localparam int BRC_NUM_BUCKS = 3;

   // Dwell per setpoint code, in picoseconds so 3.5 us stays whole
   localparam int BRC_CLK_PERIOD_PS = 20000;
   localparam int BRC_DWELL0_PS = 224000000;
   localparam int BRC_DWELL1_PS = 112000000;
   localparam int BRC_DWELL2_PS = 56000000;
   localparam int BRC_DWELL3_PS = 28000000;
   localparam int BRC_DWELL4_PS = 14000000;
   localparam int BRC_DWELL5_PS = 7000000;
   localparam int BRC_DWELL6_PS = 3500000;
   localparam int BRC_DWELL0_CYC =
      (BRC_DWELL0_PS + BRC_CLK_PERIOD_PS - 1) / BRC_CLK_PERIOD_PS;
   localparam int BRC_DWELL1_CYC =
      (BRC_DWELL1_PS + BRC_CLK_PERIOD_PS - 1) / BRC_CLK_PERIOD_PS;
   localparam int BRC_DWELL2_CYC =
      (BRC_DWELL2_PS + BRC_CLK_PERIOD_PS - 1) / BRC_CLK_PERIOD_PS;
   localparam int BRC_DWELL3_CYC =
      (BRC_DWELL3_PS + BRC_CLK_PERIOD_PS - 1) / BRC_CLK_PERIOD_PS;
   localparam int BRC_DWELL4_CYC =
      (BRC_DWELL4_PS + BRC_CLK_PERIOD_PS - 1) / BRC_CLK_PERIOD_PS;
   localparam int BRC_DWELL5_CYC =
      (BRC_DWELL5_PS + BRC_CLK_PERIOD_PS - 1) / BRC_CLK_PERIOD_PS;
   localparam int BRC_DWELL6_CYC =
      (BRC_DWELL6_PS + BRC_CLK_PERIOD_PS - 1) / BRC_CLK_PERIOD_PS;
   localparam int BRC_DWELL_W = 14;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } brc_reg_req_t;

   typedef struct packed {
      logic forced_pwm;
      logic ext_adjust;
      logic [BRC_CODE_W-1:0] code;
   } brc_buck_out_t;

   typedef enum logic [1:0] {
      BRC_IDLE = 2'b01,
      BRC_RAMP = 2'b10
   } brc_ramp_st_t;

endpackage

// File: rtl/brc_stepper.sv
// One converter's applied code, stepping toward its ramp target
module brc_stepper import brc_pkg::*; #(
   parameter logic [BRC_CODE_W-1:0] RESET_CODE = 6'h08
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [BRC_CODE_W-1:0] target,
   input wire logic tick,
   input wire logic immediate,
   output logic [BRC_CODE_W-1:0] applied
);

   typedef struct packed {
      logic [BRC_CODE_W-1:0] code;
   } brc_step_st_t;

   brc_step_st_t s_reg;
   brc_step_st_t s_next;

   always_comb begin
      s_next = s_reg;
      if (immediate) begin
         s_next.code = target;
      end else if (tick && s_reg.code < target) begin
         s_next.code = s_reg.code + 6'h01;
      end else if (tick && s_reg.code > target) begin
         s_next.code = s_reg.code - 6'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_reg.code <= RESET_CODE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign applied = s_reg.code;

endmodule // brc_stepper

// File: tb/brc_ctrl_asserts.sv
// Port checker for the ramp control and regulator register bank
module brc_ctrl_asserts import brc_pkg::*; #(
   parameter int DWELL0_CYC = BRC_DWELL0_CYC,
   parameter int DWELL1_CYC = BRC_DWELL1_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire brc_reg_req_t reg_req,
   input wire logic unlocked,
   input wire logic [7:0] rdata,
   input wire brc_buck_out_t [BRC_NUM_BUCKS-1:0] buck_out,
   input wire logic [BRC_LINREG_W-1:0] linreg1_code,
   input wire logic ramp_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic wr_ok;
   logic [2:0] pwm;
   assign wr_ok = reg_req.wr && unlocked;
   assign pwm = {buck_out[0].forced_pwm, buck_out[1].forced_pwm,
      buck_out[2].forced_pwm};
   // Rate 7 jumps, so only steps inside a running ramp are judged
   sequence s_step;
      ramp_busy && $past(ramp_busy) && $changed(buck_out[2].code);
   endsequence
   sequence s_unit;
      (buck_out[2].code == $past(buck_out[2].code) + 6'h01) ||
      (buck_out[2].code == $past(buck_out[2].code) - 6'h01);
   endsequence
   sequence s_hold;
      $stable(buck_out[2].code) [*8];
   endsequence
   a_step_unit_hold: assert property (s_step |-> s_unit ##1 s_hold)
      else $error("applied code moved by more than one per dwell");
   a_reset_values: assert property ($past(rst) |->
      linreg1_code == 4'h9 && !ramp_busy && buck_out[2].code == 6'h08
      && pwm == 3'h0)
      else $error("outputs wrong after reset");
   a_locked_ignore: assert property (reg_req.wr && !unlocked
      && reg_req.addr == BRC_ADDR_LINREG1 |=> $stable(linreg1_code))
      else $error("locked write changed the level");
   a_level_write: assert property (wr_ok && reg_req.addr ==
      BRC_ADDR_LINREG1 |=> linreg1_code == $past(reg_req.wdata[3:0]))
      else $error("level write not applied");
   a_level_read: assert property (reg_req.rd && reg_req.addr ==
      BRC_ADDR_LINREG1 |=> rdata == {4'h0, $past(linreg1_code)})
      else $error("level read mismatch");
   a_pwm_write: assert property (wr_ok && reg_req.addr ==
      BRC_ADDR_RAMP |=> pwm == $past(reg_req.wdata[5:3]))
      else $error("forced pwm bits not applied");
   a_pwm_read: assert property (reg_req.rd && reg_req.addr ==
      BRC_ADDR_RAMP |=> rdata[5:3] == $past(pwm))
      else $error("forced pwm read mismatch");
   a_ext_adjust: assert property (wr_ok && reg_req.addr ==
      BRC_ADDR_BUCK3_SET |=> buck_out[2].ext_adjust == $past(reg_req.wdata[7]))
      else $error("external adjust bit not applied");
endmodule // brc_ctrl_asserts

bind brc_ctrl brc_ctrl_asserts #(.DWELL0_CYC(DWELL0_CYC),
   .DWELL1_CYC(DWELL1_CYC)) u_chk (.clk_sys(clk_sys), .rst(rst),
   .reg_req(reg_req), .unlocked(unlocked), .rdata(rdata),
   .buck_out(buck_out), .linreg1_code(linreg1_code), .ramp_busy(ramp_busy));

// File: tb/brc_ctrl_tb.sv
// Register-level testbench for the ramp control bank
module brc_ctrl_tb import brc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   brc_reg_req_t reg_req = '0;
   logic unlocked = 1'b0;
   logic [7:0] rdata;
   brc_buck_out_t [BRC_NUM_BUCKS-1:0] buck_out;
   logic [3:0] linreg1_code;
   logic ramp_busy;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   // Short dwell for rates 0 and 1 keeps the run brief
   int dw[7] = '{40, 20, BRC_DWELL2_CYC, BRC_DWELL3_CYC, BRC_DWELL4_CYC,
      BRC_DWELL5_CYC, BRC_DWELL6_CYC};
   brc_ctrl #(.DWELL0_CYC(40), .DWELL1_CYC(20)) u_dut (.clk_sys(clk_sys),
      .rst(rst), .reg_req(reg_req), .unlocked(unlocked), .rdata(rdata),
      .buck_out(buck_out), .linreg1_code(linreg1_code),
      .ramp_busy(ramp_busy));
   always #10 clk_sys = ~clk_sys;
   task summarize;
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         summarize;
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(posedge clk_sys);
      #1;
      reg_req.wr = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      #1;
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(posedge clk_sys);
      #1;
      reg_req.rd = 1'b0;
      chk(rdata, exp);
   endtask
   task wait_code(input logic [5:0] v);
      n = 0;
      while (buck_out[2].code !== v && n < 5000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      rd(BRC_ADDR_RAMP, 8'h06);
      rd(BRC_ADDR_LINREG1, 8'h09);
      rd(BRC_ADDR_BUCK3_SET, 8'h08);
      rd(8'h20, 8'h00);
      wr(BRC_ADDR_LINREG1, 8'h03);
      rd(BRC_ADDR_LINREG1, 8'h09);
      unlocked = 1'b1;
      for (int i = 0; i < 16; i++) begin
         wr(BRC_ADDR_LINREG1, 8'hf0 | 8'(i));
         rd(BRC_ADDR_LINREG1, 8'(i));
         chk({4'h0, linreg1_code}, 8'(i));
      end
      wr(BRC_ADDR_RAMP, 8'h28);
      rd(BRC_ADDR_RAMP, 8'h28);
      chk({5'h0, buck_out[0].forced_pwm, buck_out[1].forced_pwm,
         buck_out[2].forced_pwm}, 8'h05);
      wr(BRC_ADDR_BUCK3_SET, 8'hca);
      rd(BRC_ADDR_BUCK3_SET, 8'h8a);
      chk({7'h0, buck_out[2].ext_adjust}, 8'h01);
      repeat (50) @(posedge clk_sys);
      chk({2'h0, buck_out[2].code}, 8'h08);
      for (int r = 0; r < 7; r++) begin
         wr(BRC_ADDR_BUCK3_SET, r[0] ? 8'h08 : 8'h09);
         wr(BRC_ADDR_RAMP, 8'h80 | 8'(r));
         rd(BRC_ADDR_RAMP, 8'h80 | 8'(r));
         chk({7'h0, ramp_busy}, 8'h01);
         wait_code(r[0] ? 6'h08 : 6'h09);
         chk(8'(n inside {[dw[r]-3:dw[r]+2]}), 8'h01);
         repeat (4) @(posedge clk_sys);
         rd(BRC_ADDR_RAMP, 8'(r));
         chk({7'h0, ramp_busy}, 8'h00);
      end
      wr(BRC_ADDR_BUCK1_SET, 8'h10);
      wr(BRC_ADDR_BUCK2_SET, 8'h11);
      wr(BRC_ADDR_BUCK3_SET, 8'h12);
      wr(BRC_ADDR_RAMP, 8'h87);
      repeat (3) @(posedge clk_sys);
      chk({2'h0, buck_out[0].code}, 8'h10);
      chk({2'h0, buck_out[1].code}, 8'h11);
      chk({2'h0, buck_out[2].code}, 8'h12);
      repeat (4) @(posedge clk_sys);
      rd(BRC_ADDR_RAMP, 8'h07);
      wr(BRC_ADDR_RAMP, 8'h46);
      wr(BRC_ADDR_BUCK3_SET, 8'h13);
      wait_code(6'h13);
      chk(8'(n inside {[dw[6]-3:dw[6]+3]}), 8'h01);
      rd(BRC_ADDR_RAMP, 8'h46);
      summarize;
   end
endmodule // brc_ctrl_tb
